// ===== hw/eec_classifier.sv
/*
 Error exception classifier: corrects/defers, detects consumption,
 chooses sync or async delivery and grades severity.
 Assumes one error report per cycle from the memory system; the
 pipeline samples the syndrome outputs on exc_take or serr_pend.
*/
`timescale 1ns/1ps
module eec_classifier
   import eec_pkg::*;
#(
   parameter bit LATE_REVISION = 1'b0
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire eec_err_t err_in,
   input wire logic sync_event,
   input wire logic failure_mode_sel,
   output eec_syn_t syndrome,
   output logic exc_take,
   output logic serr_pend,
   output logic fault_irq,
   output logic log_valid,
   output logic failure_mode
);

   eec_sev_t sev;
   logic silent;
   logic consumed, fixable, sync_ok, raise;
   eec_syn_t syn_reg, syn_next;
   logic exc_reg, exc_next, serr_reg, serr_next;
   logic fix_reg, fix_next, fail_reg, fail_next;
   logic level_reg, level_next;

   eec_severity u_sev (
      .err(err_in),
      .sev(sev),
      .silent(silent)
   );

   function automatic logic may_be_sync(input eec_acc_t k);
      unique case (k)
         ACC_EXPLICIT, ACC_WALK, ACC_HW_UPDATE: may_be_sync = 1'b1;
         ACC_FETCH: may_be_sync = !LATE_REVISION;
         default: may_be_sync = 1'b0;
      endcase
   endfunction

   always_comb
   begin
      fixable = err_in.valid && (err_in.correctable || err_in.deferrable);
      consumed = err_in.valid && !fixable && err_in.committed
                 && (err_in.corrupt_commit || err_in.kind == ACC_FETCH
                     || err_in.kind == ACC_WALK || err_in.kind == ACC_EXPLICIT
                     || err_in.kind == ACC_HW_UPDATE || err_in.kind == ACC_WRITE
                     || err_in.kind == ACC_CMO);
      sync_ok = may_be_sync(err_in.kind) && !err_in.speculative;
      raise = consumed && !failure_mode_sel;
      fix_next = fixable;
      fail_next = fail_reg || (consumed && failure_mode_sel);
      exc_next = raise && sync_ok;
      serr_next = raise && !sync_ok;
      syn_next = syn_reg;
      syn_next.valid = 1'b0;
      if (raise)
      begin
         syn_next.valid = 1'b1;
         syn_next.deliver_async = sync_ok ? DELIVER_SYNC : DELIVER_ASYNC;
         syn_next.severity = sev;
         syn_next.consumed = 1'b1;
         syn_next.level_sensitive = !sync_ok && err_in.level_sensitive;
      end
      // Level interrupts stay pending; a sync event does not capture them
      level_next = level_reg;
      if (serr_next && err_in.level_sensitive)
         level_next = 1'b1;
      else if (sync_event && !level_reg)
         level_next = 1'b0;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         syn_reg <= '0;
         exc_reg <= 1'b0;
         serr_reg <= 1'b0;
         fix_reg <= 1'b0;
         fail_reg <= 1'b0;
         level_reg <= 1'b0;
      end
      else
      begin
         syn_reg <= syn_next;
         exc_reg <= exc_next;
         serr_reg <= serr_next;
         fix_reg <= fix_next;
         fail_reg <= fail_next;
         level_reg <= level_next;
      end
   end

   assign syndrome = syn_reg;
   assign exc_take = exc_reg;
   assign serr_pend = serr_reg || level_reg;
   assign fault_irq = fix_reg;
   assign log_valid = fix_reg;
   assign failure_mode = fail_reg;

   sequence s_fixable;
      err_in.valid && (err_in.correctable || err_in.deferrable);
   endsequence

   // A raised abort, then its registered answer one cycle later
   sequence s_raise_sync;
      raise && sync_ok;
   endsequence

   sequence s_raise_async;
      raise && !sync_ok;
   endsequence

   sequence s_sync_answer;
      exc_take && !serr_reg && syndrome.valid && syndrome.deliver_async == DELIVER_SYNC;
   endsequence

   sequence s_async_answer;
      serr_pend && !exc_take && syndrome.valid && syndrome.deliver_async == DELIVER_ASYNC;
   endsequence

   sequence s_answer_gone;
      !exc_take && !serr_reg && !syndrome.valid;
   endsequence

   a_fix_irq: assert property (@(posedge mclk) disable iff (reset)
      s_fixable |=> fault_irq && log_valid && !exc_take)
      else $error("fixable error did not raise fault interrupt");
   a_fix_no_abort: assert property (@(posedge mclk) disable iff (reset)
      s_fixable |=> !syndrome.valid && !serr_reg)
      else $error("fixable error raised an abort");
   a_consumed_acts: assert property (@(posedge mclk) disable iff (reset)
      consumed |=> exc_take || serr_pend || failure_mode)
      else $error("consumed error handled silently");
   a_fail_sticky: assert property (@(posedge mclk) disable iff (reset)
      failure_mode |=> failure_mode)
      else $error("failure mode left without reset");
   a_commit_consumed: assert property (@(posedge mclk) disable iff (reset)
      err_in.valid && !fixable && err_in.committed && !failure_mode_sel
      && (err_in.corrupt_commit || err_in.kind inside {ACC_WALK, ACC_FETCH})
      |=> syndrome.valid && syndrome.consumed)
      else $error("consumed error not reported");
   a_read_abort: assert property (@(posedge mclk) disable iff (reset)
      err_in.valid && !fixable && err_in.committed && !failure_mode_sel
      && err_in.kind == ACC_EXPLICIT && !err_in.speculative |=> exc_take)
      else $error("read abort not raised");
   a_write_abort: assert property (@(posedge mclk) disable iff (reset)
      err_in.valid && !fixable && err_in.committed && !failure_mode_sel
      && err_in.kind inside {ACC_WRITE, ACC_CMO} |=> serr_pend && syndrome.valid)
      else $error("write or maintenance abort not raised");
   a_one_delivery: assert property (@(posedge mclk) disable iff (reset)
      !(exc_take && serr_reg))
      else $error("abort delivered both ways");
   a_sync_answer: assert property (@(posedge mclk) disable iff (reset)
      s_raise_sync |=> s_sync_answer)
      else $error("synchronous abort answer missing");
   a_async_answer: assert property (@(posedge mclk) disable iff (reset)
      s_raise_async |=> s_async_answer)
      else $error("asynchronous abort answer missing");
   a_sync_kinds: assert property (@(posedge mclk) disable iff (reset)
      raise && !sync_ok |=> serr_pend && !exc_take)
      else $error("illegal synchronous abort");
   a_silent_uncontainable: assert property (@(posedge mclk) disable iff (reset)
      raise && silent |=> syndrome.severity == SEV_UNCONTAINABLE)
      else $error("silent error not uncontainable");
   a_contained_reg: assert property (@(posedge mclk) disable iff (reset)
      raise && err_in.prop_gpr_only && err_in.prop_after_sync && !err_in.prop_other_path
      && !err_in.contain_unknown |=> syndrome.severity != SEV_UNCONTAINABLE)
      else $error("contained propagation graded uncontainable");
   a_silent_raw: assert property (@(posedge mclk) disable iff (reset)
      raise && err_in.silent_prop && !err_in.prop_gpr_only
      |=> syndrome.severity == SEV_UNCONTAINABLE)
      else $error("unsignalled propagation not uncontainable");
   a_consumed_sev: assert property (@(posedge mclk) disable iff (reset)
      raise && (err_in.corrupt_commit || err_in.kind inside {ACC_WALK, ACC_FETCH})
      |=> syndrome.severity inside {SEV_UNRECOVERABLE, SEV_UNCONTAINABLE})
      else $error("consumed error graded resumable");
   a_repair_sev: assert property (@(posedge mclk) disable iff (reset)
      raise && err_in.needs_sw_repair |=> syndrome.severity != SEV_RESTARTABLE)
      else $error("repair-needing error graded restartable");
   a_restart_sev: assert property (@(posedge mclk) disable iff (reset)
      raise && !silent && !err_in.contain_unknown && !err_in.infected && err_in.precise
      && !err_in.corrupt_commit && !err_in.needs_sw_repair
      && !(err_in.kind inside {ACC_WALK, ACC_FETCH})
      |=> syndrome.severity == SEV_RESTARTABLE)
      else $error("restartable state graded harsher");
   a_sync_syndrome: assert property (@(posedge mclk) disable iff (reset)
      exc_take |-> syndrome.valid && syndrome.deliver_async == DELIVER_SYNC)
      else $error("sync abort without syndrome");
   a_infected_sev: assert property (@(posedge mclk) disable iff (reset)
      raise && (err_in.infected || !err_in.precise)
      |=> syndrome.severity inside {SEV_UNRECOVERABLE, SEV_UNCONTAINABLE})
      else $error("severity reported too mild");
   a_level_held: assert property (@(posedge mclk) disable iff (reset)
      level_reg && sync_event |=> level_reg)
      else $error("level interrupt captured by sync event");
   a_level_flag: assert property (@(posedge mclk) disable iff (reset)
      raise && !sync_ok && err_in.level_sensitive |=> serr_pend && syndrome.level_sensitive)
      else $error("level interrupt not flagged");
   a_unknown_containment: assert property (@(posedge mclk) disable iff (reset)
      raise && err_in.contain_unknown |=> syndrome.severity == SEV_UNCONTAINABLE)
      else $error("unknown containment not uncontainable");
   a_pulse_once: assert property (@(posedge mclk) disable iff (reset)
      raise ##1 !raise |=> s_answer_gone)
      else $error("abort answer stood too long");
   a_sev_stable: assert property (@(posedge mclk) disable iff (reset)
      !raise |=> $stable(syndrome.severity))
      else $error("severity changed without a raise");

endmodule // eec_classifier

// ===== hw/eec_pkg.sv
/*
 Shared types and constants of the error exception classifier.
 Assumes a single core clock domain; no software-visible registers.
*/
package eec_pkg;

   // Severity encoding, ordered by increasing severity
   typedef enum logic [1:0] {
      SEV_RESTARTABLE    = 2'h0,
      SEV_RECOVERABLE    = 2'h1,
      SEV_UNRECOVERABLE  = 2'h2,
      SEV_UNCONTAINABLE  = 2'h3
   } eec_sev_t;

   // Access kinds that may carry an error
   typedef enum logic [2:0] {
      ACC_EXPLICIT   = 3'h0,
      ACC_WALK       = 3'h1,
      ACC_HW_UPDATE  = 3'h2,
      ACC_FETCH      = 3'h3,
      ACC_WRITE      = 3'h4,
      ACC_CMO        = 3'h5,
      ACC_OTHER      = 3'h6
   } eec_acc_t;

   localparam logic DELIVER_SYNC = 1'h0;
   localparam logic DELIVER_ASYNC = 1'h1;

   // One detected error report from the memory system / nodes
   typedef struct packed {
      logic valid;
      eec_acc_t kind;
      logic speculative;
      logic correctable;
      logic deferrable;
      logic committed;
      logic corrupt_commit;
      logic silent_prop;
      logic prop_gpr_only;
      logic prop_after_sync;
      logic prop_other_path;
      logic contain_unknown;
      logic precise;
      logic infected;
      logic needs_sw_repair;
      logic level_sensitive;
   } eec_err_t;

   // Classification result for the syndrome logic
   typedef struct packed {
      logic valid;
      logic deliver_async;
      eec_sev_t severity;
      logic consumed;
      logic level_sensitive;
   } eec_syn_t;

   localparam logic [1:0] SEV_RESET = 2'h0;

endpackage

// ===== hw/eec_severity.sv
/*
 Combinational severity decode of one error report.
 Assumes the report fields are stable in the cycle they are valid.
*/
`timescale 1ns/1ps
module eec_severity
   import eec_pkg::*;
(
   input wire eec_err_t err,
   output eec_sev_t sev,
   output logic silent
);

   logic contained;

   always_comb
   begin
      // Late silent propagation of a register-only value stays contained
      contained = err.prop_gpr_only && err.prop_after_sync
                  && !err.prop_other_path;
      silent = err.silent_prop && !contained;
      // Never report milder than the true state
      if (silent || err.contain_unknown)
         sev = SEV_UNCONTAINABLE;
      // Infected, imprecise, corrupt-commit and committed fetch/walk errors can never resume as restartable
      else if (err.infected || !err.precise || err.corrupt_commit
               || (err.committed && (err.kind == ACC_FETCH || err.kind == ACC_WALK)))
         sev = SEV_UNRECOVERABLE;
      else if (err.needs_sw_repair)
         sev = SEV_RECOVERABLE;
      else
         sev = SEV_RESTARTABLE;
   end

endmodule // eec_severity

// ===== verif/eec_mem_model.sv
/*
 Memory-side model that raises error reports toward the classifier.
 Assumes the caller enters a task just after a rising edge.
*/
`timescale 1ns/1ps
module eec_mem_model
   import eec_pkg::*;
(
   input wire logic mclk,
   output eec_err_t err
);
   initial err = '0;
   // Held until the taking edge; back to back allowed
   task automatic issue(input eec_err_t e);
      err = e;
      @(posedge mclk);
      #1;
   endtask
   // Released bus shows inverted leftovers with valid low; a second idle in a row restores the stale report fields
   task automatic idle();
      eec_err_t t;
      t = ~err;
      t.valid = 1'b0;
      err = t;
      @(posedge mclk);
      #1;
   endtask
endmodule // eec_mem_model

// ===== verif/test_eec_classifier.sv
/*
 Self-checking bench of the classifier against a reference model.
 Assumes LATE_REVISION left at 0 and one-cycle registered answers.
*/
`timescale 1ns/1ps
module test_eec_classifier
   import eec_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic sync_event = 1'b0;
   logic failure_mode_sel = 1'b0;
   eec_err_t err_in;
   eec_syn_t syndrome;
   logic exc_take, serr_pend, fault_irq, log_valid, failure_mode;
   int bad_count = 0;
   int n_compared = 0;
   always #5 mclk = ~mclk;
   eec_mem_model u_eec_mem_model (.mclk(mclk), .err(err_in));
   eec_classifier u_eec_classifier (.mclk(mclk), .reset(reset), .err_in(err_in),
      .sync_event(sync_event), .failure_mode_sel(failure_mode_sel), .syndrome(syndrome),
      .exc_take(exc_take), .serr_pend(serr_pend), .fault_irq(fault_irq),
      .log_valid(log_valid), .failure_mode(failure_mode));
   task automatic chk(input string n, input logic [1:0] x, input logic [1:0] g);
      n_compared++;
      if (g !== x)
      begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", n, x, g);
      end
   endtask
   task automatic run(input eec_err_t e);
      logic fix, act, asy, uc, cons;
      logic [1:0] sev;
      u_eec_mem_model.issue(e);
      fix = e.correctable | e.deferrable;
      // Corrupt data committed counts as consumed whatever the access kind
      act = e.valid & !fix & e.committed & (e.corrupt_commit | (e.kind != ACC_OTHER));
      asy = e.speculative | (e.kind > ACC_FETCH);
      uc = e.contain_unknown | (e.silent_prop
         & !(e.prop_gpr_only & e.prop_after_sync & !e.prop_other_path));
      cons = e.corrupt_commit | (e.committed & (e.kind inside {ACC_WALK, ACC_FETCH}));
      sev = uc ? 2'h3 : (cons | e.infected | !e.precise) ? 2'h2 : {1'b0, e.needs_sw_repair};
      chk("fault_irq", e.valid & fix, fault_irq);
      chk("log_valid", e.valid & fix, log_valid);
      chk("exc_take", act & !asy, exc_take);
      chk("serr_pend", act & asy, serr_pend);
      chk("syn_valid", act, syndrome.valid);
      chk("failure_quiet", 2'h0, failure_mode);
      if (act)
      begin
         chk("deliver", asy, syndrome.deliver_async);
         chk("syn_consumed", 2'h1, syndrome.consumed);
         chk("syn_level", asy & e.level_sensitive, syndrome.level_sensitive);
         // Milder-than-real is the fault; harsher grading is legal
         if (uc)
            chk("severity", sev, syndrome.severity);
         else
            chk("sev_floor", 2'h1, {1'b0, syndrome.severity >= sev});
      end
   endtask
   task automatic results();
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      eec_err_t e;
      logic [31:0] r;
      void'($urandom(31178));
      repeat (2) @(posedge mclk);
      #1 reset = 1'b0;
      for (int i = 0; i < 400; i++)
      begin
         r = $urandom();
         e = r[$bits(eec_err_t)-1:0];
         e.kind = eec_acc_t'(3'($urandom() % 7));
         e.correctable = r[31] & r[30];
         e.deferrable = r[29] & r[28] & r[27];
         e.committed = e.committed | r[26];
         e.level_sensitive = 1'b0;
         run(e);
      end
      for (int k = 0; k < 14; k++)
      begin
         e = '0;
         e.valid = 1'b1;
         e.committed = 1'b1;
         e.precise = 1'b1;
         e.kind = eec_acc_t'(3'(k / 2));
         e.speculative = k[0];
         run(e);
      end
      e.kind = ACC_WRITE;
      e.speculative = 1'b0;
      e.level_sensitive = 1'b1;
      run(e);
      sync_event = 1'b1;
      u_eec_mem_model.idle();
      sync_event = 1'b0;
      repeat (3) u_eec_mem_model.idle();
      chk("serr_level", 2'h1, serr_pend);
      reset = 1'b1;
      repeat (2) u_eec_mem_model.idle();
      reset = 1'b0;
      chk("serr_reset", 2'h0, serr_pend);
      failure_mode_sel = 1'b1;
      e.level_sensitive = 1'b0;
      e.kind = ACC_EXPLICIT;
      u_eec_mem_model.issue(e);
      // Pulses stand only this one cycle, so look for them now
      chk("exc_quiet", 2'h0, exc_take);
      chk("serr_quiet", 2'h0, serr_pend);
      repeat (2) u_eec_mem_model.idle();
      chk("failure", 2'h1, failure_mode);
      results();
   end
endmodule // test_eec_classifier
